// *** rtl/cic_pkg.sv ***
// package: constants, register map, types for the chipper intake control
package cic_pkg;
	localparam int          CLK_HZ        = 40_000_000;
	localparam int          PERIOD_W      = 24;
	localparam int          PULSES_REV    = 1;
	// timing figures in their own units
	localparam int          DEB_TIME_MS   = 10;
	localparam int          FLASH_TIME_MS = 250;
	localparam int          DM1_HOLD_MS   = 3000;
	localparam int          REV_TIME_MS   = 500;
	localparam int          DEB_CYC       = CLK_HZ / 1000 * DEB_TIME_MS;
	localparam int          FLASH_CYC     = CLK_HZ / 1000 * FLASH_TIME_MS;
	localparam int          DM1_HOLD_CYC  = CLK_HZ / 1000 * DM1_HOLD_MS;
	localparam int          REV_CYC       = CLK_HZ / 1000 * REV_TIME_MS;
	// default thresholds in rpm, kept as pulse periods in clock cycles
	localparam longint      RPM_MIN       = 1500;
	localparam longint      RPM_RET       = 1550;
	localparam longint      RPM_NORM      = 1600;
	localparam longint      RPM_MAX       = 1850;
	localparam longint      CYC_MIN       = 64'd60 * CLK_HZ;
	localparam logic [31:0] PER_MIN_RST   = 32'(CYC_MIN / (RPM_MIN * PULSES_REV));
	localparam logic [31:0] PER_RET_RST   = 32'(CYC_MIN / (RPM_RET * PULSES_REV));
	localparam logic [31:0] PER_NORM_RST  = 32'(CYC_MIN / (RPM_NORM * PULSES_REV));
	localparam logic [31:0] PER_MAX_RST   = 32'(CYC_MIN / (RPM_MAX * PULSES_REV));
	localparam logic [31:0] REV_DUR_RST   = 32'(REV_CYC);
	localparam logic [31:0] SVC_INT_RST   = 32'h0000_01F4;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_THR_MIN   = 8'h04;
	localparam logic [7:0]  OFS_THR_RET   = 8'h08;
	localparam logic [7:0]  OFS_THR_NORM  = 8'h0C;
	localparam logic [7:0]  OFS_THR_MAX   = 8'h10;
	localparam logic [7:0]  OFS_REV_DUR   = 8'h14;
	localparam logic [7:0]  OFS_SVC_HOURS = 8'h18;
	localparam logic [7:0]  OFS_SVC_INT   = 8'h1C;
	localparam logic [7:0]  OFS_STATUS    = 8'h20;
	localparam logic [7:0]  OFS_PERIOD    = 8'h24;
	// control register fields
	localparam int          CTRL_NET_BIT  = 0;
	localparam int          CTRL_PROF_BIT = 1;
	localparam logic [1:0]  CTRL_RST      = 2'h0;
	// button vector positions
	localparam int          BTN_START     = 0;
	localparam int          BTN_STOP      = 1;
	localparam int          BTN_REV       = 2;
	localparam int          BTN_CONFIRM   = 3;
	localparam int          BTN_COVER     = 4;
	localparam int          BTN_N         = 5;

	typedef enum logic [2:0] {
		ST_WAIT_START,
		ST_RUN,
		ST_UNDER,
		ST_OVER,
		ST_COVER,
		ST_COVER_OK
	} cic_state_t;

	typedef struct packed {
		logic [PERIOD_W-1:0] per_min;
		logic [PERIOD_W-1:0] per_ret;
		logic [PERIOD_W-1:0] per_norm;
		logic [PERIOD_W-1:0] per_max;
	} cic_thr_t;

	typedef struct packed {
		logic red;
		logic amber;
	} cic_lamp_t;
endpackage

// *** rtl/cic_intake_ctrl.sv ***
// intake speed control: speed measure, intake state machine, indicators, apb registers
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module cic_intake_ctrl #(
	parameter int DEBOUNCE_CYC = cic_pkg::DEB_CYC,
	parameter int FLASH_CYC    = cic_pkg::FLASH_CYC,
	parameter int DM1_HOLD_CYC = cic_pkg::DM1_HOLD_CYC
) (
	input  wire logic                      clock_in,       // 40 MHz system clock
	input  wire logic                      reset_n_in,     // synchronous reset, low
	input  wire logic                      psel_in,        // apb select
	input  wire logic                      penable_in,     // apb access phase
	input  wire logic                      pwrite_in,      // apb write
	input  wire logic [7:0]                paddr_in,       // apb byte address
	input  wire logic [31:0]               pwdata_in,      // apb write data
	output logic      [31:0]               prdata_out,     // apb read data
	output logic                           pready_out,     // apb ready
	output logic                           pslverr_out,    // apb unmapped address
	input  wire logic [cic_pkg::BTN_N-1:0] btn_in,         // start,stop,rev,confirm,cover
	input  wire logic                      rotor_pulse_in, // rotor speed sensor
	input  wire logic                      dm1_strobe_in,  // one dm1 message received
	input  wire cic_pkg::cic_lamp_t        dm1_lamp_in,    // lamp bits of that message
	output logic                           intake_out,     // intake forward drive
	output logic                           reverse_out,    // intake reverse drive
	output logic                           alarm_out,      // alarm output
	output logic                           led_green_out,  // speed pulse indicator
	output logic                           led_red_out,    // fault indicator
	output logic                           push_start_out, // push-start request
	output logic                           in_range_out,   // speed in working range
	output logic                           idle_cmd_out,   // engine idle command
	output logic                           svc_flash_out,  // service indication
	output logic                           fault_page_out  // fault page selected
);
	// refuse counts that the counters below cannot serve
	if (DEBOUNCE_CYC < 1 || FLASH_CYC < 2 || DM1_HOLD_CYC < 1) begin : g_bad_param
		$error("cic_intake_ctrl: counts must be positive");
	end

	// debounce: 2-flop sync, then a level must stay stable for DEBOUNCE_CYC
	logic [cic_pkg::BTN_N-1:0] sync1_reg, sync2_reg, deb_reg, deb_q_reg, deb_next;
	logic [31:0]               deb_cnt_reg [cic_pkg::BTN_N];
	logic [31:0]               deb_cnt_next[cic_pkg::BTN_N];
	// one process for all buttons, so each vector has a single writer
	always_comb begin
		for (int i = 0; i < cic_pkg::BTN_N; i++) begin
			deb_next[i]     = deb_reg[i];
			deb_cnt_next[i] = 32'h0000_0000;
			if (sync2_reg[i] != deb_reg[i]) begin
				deb_cnt_next[i] = deb_cnt_reg[i] + 32'h0000_0001;
				if (deb_cnt_reg[i] >= 32'(DEBOUNCE_CYC - 1)) begin
					deb_next[i]     = sync2_reg[i];
					deb_cnt_next[i] = 32'h0000_0000;
				end
			end
		end
	end
	always_ff @(posedge clock_in) begin
		for (int i = 0; i < cic_pkg::BTN_N; i++) begin
			if (!reset_n_in)
				deb_cnt_reg[i] <= 32'h0000_0000;
			else
				deb_cnt_reg[i] <= deb_cnt_next[i];
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			deb_reg   <= '0;
			deb_q_reg <= '0;
		end else begin
			sync1_reg <= btn_in;
			sync2_reg <= sync1_reg;
			deb_reg   <= deb_next;
			deb_q_reg <= deb_reg;
		end
	end

	logic [cic_pkg::BTN_N-1:0] press;
	assign press = deb_reg & ~deb_q_reg;
	logic start_p, stop_p, confirm_p, rev_held, cover_on;
	assign start_p   = press[cic_pkg::BTN_START];
	assign stop_p    = press[cic_pkg::BTN_STOP];
	assign confirm_p = press[cic_pkg::BTN_CONFIRM];
	assign rev_held  = deb_reg[cic_pkg::BTN_REV];
	assign cover_on  = deb_reg[cic_pkg::BTN_COVER];

	// speed: cycles between pulses; stationary rotor saturates the count
	localparam logic [cic_pkg::PERIOD_W-1:0] PER_SAT = '1;
	localparam logic [cic_pkg::PERIOD_W-1:0] PER_ONE = {{(cic_pkg::PERIOD_W-1){1'b0}}, 1'b1};
	logic [2:0]                    pls_reg;
	logic [cic_pkg::PERIOD_W-1:0]  pcnt_reg, pcnt_next, period_reg, period_next;
	logic                          pulse_ev;
	assign pulse_ev = pls_reg[1] & ~pls_reg[2];
	always_comb begin
		pcnt_next   = (pcnt_reg == PER_SAT) ? pcnt_reg : pcnt_reg + PER_ONE;
		period_next = period_reg;
		if (pulse_ev) begin
			period_next = pcnt_reg;
			pcnt_next   = '0;
		end else if (pcnt_reg == PER_SAT) begin
			period_next = PER_SAT;
		end
	end
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			pls_reg    <= 3'h0;
			pcnt_reg   <= '0;
			period_reg <= '1;
		end else begin
			pls_reg    <= {pls_reg[1:0], rotor_pulse_in};
			pcnt_reg   <= pcnt_next;
			period_reg <= period_next;
		end
	end

	// registers written by software
	logic [1:0]          ctrl_reg, ctrl_next;
	cic_pkg::cic_thr_t   thr_reg, thr_next;
	logic [31:0]         rev_dur_reg, rev_dur_next, hours_reg, hours_next, svc_int_reg, svc_int_next;

	// threshold comparisons: a shorter period is a higher speed
	logic below_min, above_ret, above_norm, below_norm, above_max;
	always_comb begin
		below_min  = period_reg > thr_reg.per_min;
		above_ret  = period_reg < thr_reg.per_ret;
		above_norm = period_reg < thr_reg.per_norm;
		below_norm = period_reg > thr_reg.per_norm;
		above_max  = period_reg < thr_reg.per_max;
	end

	// intake state machine; reverse holding sits beside it, leaving state intact
	cic_pkg::cic_state_t state_reg, state_next;
	logic [31:0]         rev_cnt_reg, rev_cnt_next;
	always_comb begin
		state_next   = state_reg;
		rev_cnt_next = (rev_cnt_reg != 32'h0000_0000) ? rev_cnt_reg - 32'h0000_0001 : rev_cnt_reg;
		case (state_reg)
			cic_pkg::ST_WAIT_START: begin
				if (start_p && (above_norm || above_ret) && !above_max)
					state_next = cic_pkg::ST_RUN;
			end
			cic_pkg::ST_RUN: begin
				if (above_max) begin
					state_next = cic_pkg::ST_OVER;
				end else if (below_min) begin
					state_next   = cic_pkg::ST_UNDER;
					rev_cnt_next = rev_dur_reg;
				end
			end
			cic_pkg::ST_UNDER: begin
				if (above_ret && !above_max)
					state_next = cic_pkg::ST_RUN;
			end
			cic_pkg::ST_OVER: begin
				if (below_norm)
					state_next = cic_pkg::ST_RUN;
			end
			cic_pkg::ST_COVER: begin
				if (!cover_on && confirm_p)
					state_next = cic_pkg::ST_COVER_OK;
			end
			cic_pkg::ST_COVER_OK: begin
				if (start_p)
					state_next = cic_pkg::ST_RUN;
			end
			default: state_next = cic_pkg::ST_WAIT_START;
		endcase
		// stop outside a cover fault returns to waiting for start
		if (stop_p && state_reg != cic_pkg::ST_COVER && state_reg != cic_pkg::ST_COVER_OK)
			state_next = cic_pkg::ST_WAIT_START;
		if (cover_on)
			state_next = cic_pkg::ST_COVER;
		if (stop_p || cover_on || rev_held)
			rev_cnt_next = 32'h0000_0000;
	end
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			state_reg   <= cic_pkg::ST_WAIT_START;
			rev_cnt_reg <= 32'h0000_0000;
		end else begin
			state_reg   <= state_next;
			rev_cnt_reg <= rev_cnt_next;
		end
	end

	// flash divider and dm1 hold timer
	logic [31:0]        fl_cnt_reg, fl_cnt_next, dm1_cnt_reg, dm1_cnt_next;
	logic               flash_reg, flash_next;
	cic_pkg::cic_lamp_t lamp_reg, lamp_next;
	logic               net;
	assign net = ctrl_reg[cic_pkg::CTRL_NET_BIT];
	always_comb begin
		fl_cnt_next  = fl_cnt_reg + 32'h0000_0001;
		flash_next   = flash_reg;
		if (fl_cnt_reg >= 32'(FLASH_CYC - 1)) begin
			fl_cnt_next = 32'h0000_0000;
			flash_next  = !flash_reg;
		end
		lamp_next    = lamp_reg;
		dm1_cnt_next = dm1_cnt_reg;
		if (net && dm1_strobe_in) begin
			lamp_next    = dm1_lamp_in;
			dm1_cnt_next = 32'(DM1_HOLD_CYC);
		end else if (dm1_cnt_reg != 32'h0000_0000) begin
			dm1_cnt_next = dm1_cnt_reg - 32'h0000_0001;
		end else begin
			lamp_next = '0;
		end
		if (!net)
			lamp_next = '0;
	end
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			fl_cnt_reg  <= 32'h0000_0000;
			flash_reg   <= 1'b0;
			dm1_cnt_reg <= 32'h0000_0000;
			lamp_reg    <= '0;
		end else begin
			fl_cnt_reg  <= fl_cnt_next;
			flash_reg   <= flash_next;
			dm1_cnt_reg <= dm1_cnt_next;
			lamp_reg    <= lamp_next;
		end
	end

	// outputs, all registered; next values follow the next state
	logic dm1_fault;
	assign dm1_fault = lamp_reg.red | lamp_reg.amber;
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			intake_out     <= 1'b0;
			reverse_out    <= 1'b0;
			alarm_out      <= 1'b0;
			led_green_out  <= 1'b0;
			led_red_out    <= 1'b0;
			push_start_out <= 1'b0;
			in_range_out   <= 1'b0;
			idle_cmd_out   <= 1'b0;
			svc_flash_out  <= 1'b0;
			fault_page_out <= 1'b0;
		end else begin
			intake_out     <= state_next == cic_pkg::ST_RUN && !rev_held;
			reverse_out    <= rev_held || rev_cnt_next != 32'h0000_0000;
			alarm_out      <= cover_on || state_next == cic_pkg::ST_COVER || lamp_reg.red;
			led_green_out  <= pulse_ev ? !led_green_out : led_green_out;
			led_red_out    <= cover_on || lamp_reg.red || (lamp_reg.amber && flash_reg);
			push_start_out <= state_next == cic_pkg::ST_WAIT_START
				|| state_next == cic_pkg::ST_COVER_OK;
			in_range_out   <= above_ret && !above_max;
			idle_cmd_out   <= net && !ctrl_reg[cic_pkg::CTRL_PROF_BIT];
			svc_flash_out  <= hours_reg > svc_int_reg && flash_reg;
			fault_page_out <= dm1_fault && flash_reg;
		end
	end

	// apb slave: one wait-free access, answer in the access cycle
	logic        wr_en, mapped;
	logic [31:0] rd_data;
	assign wr_en = psel_in && penable_in && pready_out && pwrite_in;
	always_comb begin
		mapped  = 1'b1;
		rd_data = 32'h0000_0000;
		case (paddr_in)
			cic_pkg::OFS_CTRL:      rd_data = {30'h0000_0000, ctrl_reg};
			cic_pkg::OFS_THR_MIN:   rd_data = 32'(thr_reg.per_min);
			cic_pkg::OFS_THR_RET:   rd_data = 32'(thr_reg.per_ret);
			cic_pkg::OFS_THR_NORM:  rd_data = 32'(thr_reg.per_norm);
			cic_pkg::OFS_THR_MAX:   rd_data = 32'(thr_reg.per_max);
			cic_pkg::OFS_REV_DUR:   rd_data = rev_dur_reg;
			cic_pkg::OFS_SVC_HOURS: rd_data = hours_reg;
			cic_pkg::OFS_SVC_INT:   rd_data = svc_int_reg;
			cic_pkg::OFS_STATUS:    rd_data = {22'h0000_00, lamp_reg, intake_out, reverse_out,
				alarm_out, in_range_out, push_start_out, state_reg};
			cic_pkg::OFS_PERIOD:    rd_data = 32'(period_reg);
			default:                mapped  = 1'b0;
		endcase
		ctrl_next    = ctrl_reg;
		thr_next     = thr_reg;
		rev_dur_next = rev_dur_reg;
		hours_next   = hours_reg;
		svc_int_next = svc_int_reg;
		if (wr_en) begin
			case (paddr_in)
				cic_pkg::OFS_CTRL:      ctrl_next         = pwdata_in[1:0];
				cic_pkg::OFS_THR_MIN:   thr_next.per_min  = pwdata_in[cic_pkg::PERIOD_W-1:0];
				cic_pkg::OFS_THR_RET:   thr_next.per_ret  = pwdata_in[cic_pkg::PERIOD_W-1:0];
				cic_pkg::OFS_THR_NORM:  thr_next.per_norm = pwdata_in[cic_pkg::PERIOD_W-1:0];
				cic_pkg::OFS_THR_MAX:   thr_next.per_max  = pwdata_in[cic_pkg::PERIOD_W-1:0];
				cic_pkg::OFS_REV_DUR:   rev_dur_next      = pwdata_in;
				cic_pkg::OFS_SVC_HOURS: hours_next        = pwdata_in;
				cic_pkg::OFS_SVC_INT:   svc_int_next      = pwdata_in;
				default:                ctrl_next         = ctrl_reg;
			endcase
		end
	end
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			ctrl_reg      <= cic_pkg::CTRL_RST;
			thr_reg       <= {cic_pkg::PER_MIN_RST[cic_pkg::PERIOD_W-1:0],
				cic_pkg::PER_RET_RST[cic_pkg::PERIOD_W-1:0],
				cic_pkg::PER_NORM_RST[cic_pkg::PERIOD_W-1:0],
				cic_pkg::PER_MAX_RST[cic_pkg::PERIOD_W-1:0]};
			rev_dur_reg   <= cic_pkg::REV_DUR_RST;
			hours_reg     <= 32'h0000_0000;
			svc_int_reg   <= cic_pkg::SVC_INT_RST;
			pready_out    <= 1'b0;
			pslverr_out   <= 1'b0;
			prdata_out    <= 32'h0000_0000;
		end else begin
			ctrl_reg      <= ctrl_next;
			thr_reg       <= thr_next;
			rev_dur_reg   <= rev_dur_next;
			hours_reg     <= hours_next;
			svc_int_reg   <= svc_int_next;
			pready_out    <= psel_in && !penable_in;
			pslverr_out   <= psel_in && !penable_in && !mapped;
			prdata_out    <= (psel_in && !penable_in && !pwrite_in) ? rd_data : 32'h0000_0000;
		end
	end

	// checks on the intake behaviour
	cover_off_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		cover_on |=> !intake_out && alarm_out)
		else $error("intake not off on cover switch");
	stop_off_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		stop_p |=> !intake_out ##1 (!intake_out || $past(start_p, 1)))
		else $error("intake not halted by stop");
	confirm_order_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(state_reg == cic_pkg::ST_COVER && !confirm_p) |=> !intake_out)
		else $error("intake on before confirm");
	max_off_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(above_max && state_reg != cic_pkg::ST_WAIT_START) |=> ##1 !intake_out)
		else $error("intake on above maximum");
	reverse_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		rev_held [*2] |-> reverse_out && !intake_out)
		else $error("reverse not driven while held");
	green_toggle_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		pulse_ev |=> led_green_out != $past(led_green_out))
		else $error("green indicator missed a pulse");
	red_alarm_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		lamp_reg.red |=> alarm_out && led_red_out)
		else $error("red stop lamp not on alarm");
	idle_cmd_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		$rose(net && !ctrl_reg[cic_pkg::CTRL_PROF_BIT]) |=> idle_cmd_out)
		else $error("idle not commanded");
	push_req_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(state_reg == cic_pkg::ST_WAIT_START && !start_p && !cover_on) |=> push_start_out)
		else $error("push-start request missing");
	range_flag_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(above_ret && !above_max) |=> in_range_out)
		else $error("in-range flag missing");
endmodule

// *** bench/cic_far_end.sv ***
// far-side model: rotor sensor pulses and engine controller lamp messages
`timescale 1ns/10ps
module cic_far_end (
	input  wire logic               clock_in,   // system clock
	input  wire logic [23:0]        period_in,  // pulse spacing in cycles, 0 = rotor still
	input  wire cic_pkg::cic_lamp_t lamp_in,    // lamp state the engine reports
	output logic                    pulse_out,  // rotor sensor line
	output logic                    strobe_out, // one lamp message
	output cic_pkg::cic_lamp_t      lamp_out    // lamp bits of that message
);
	logic [23:0] pcnt = 24'h00_0000;
	logic [4:0]  mcnt = 5'h00;
	initial begin
		pulse_out = 1'b0;
		strobe_out = 1'b0;
		lamp_out = 2'h0;
	end
	// two-cycle sensor pulse every period_in cycles; a still rotor gives none
	always @(posedge clock_in) begin
		pcnt <= (pcnt + 24'h00_0001 >= period_in) ? 24'h00_0000 : pcnt + 24'h00_0001;
		pulse_out <= (period_in != 24'h00_0000) && (pcnt < 24'h00_0002);
	end
	// messages repeat while the fault lasts; lamp bits are junk between them
	always @(posedge clock_in) begin
		mcnt <= mcnt + 5'h01;
		strobe_out <= (lamp_in != 2'h0) && (mcnt == 5'h00);
		lamp_out <= ((lamp_in != 2'h0) && (mcnt == 5'h00)) ? lamp_in : ~lamp_out;
	end
endmodule

// *** bench/tb.sv ***
// self-checking bench for the chipper intake control
`timescale 1ns/10ps
module tb;
	localparam int ix_in = 0, ix_rv = 1, ix_al = 2, ix_gr = 3, ix_rd = 4;
	localparam int ix_ps = 5, ix_ir = 6, ix_id = 7, ix_sv = 8, ix_pg = 9;
	localparam logic [31:0] z = 32'h0000_0000;
	localparam logic [31:0] thr [5] = '{32'h0000_0190, 32'h0000_012C, 32'h0000_00FA,
		32'h0000_0096, 32'h0000_0014};
	logic               clock_in = 1'b0;
	logic               reset_n_in = 1'b0;
	logic               psel_in = 1'b0;
	logic               penable_in = 1'b0;
	logic               pwrite_in = 1'b0;
	logic [7:0]         paddr_in = 8'h00;
	logic [31:0]        pwdata_in = 32'h0000_0000;
	logic [31:0]        prdata_out, rd;
	logic               pready_out, pslverr_out, re, rotor_pulse_in, dm1_strobe_in;
	logic [4:0]         btn_in = 5'h00;
	logic [23:0]        rotor_per = 24'h00_0000;
	cic_pkg::cic_lamp_t dm1_lamp_in;
	cic_pkg::cic_lamp_t lamp_req = 2'h0;
	wire  [9:0]         outs;
	int                 err_total = 0, checked = 0;

	// 40 MHz clock
	always #12.5 clock_in = ~clock_in;

	cic_intake_ctrl #(.DEBOUNCE_CYC(4), .FLASH_CYC(8), .DM1_HOLD_CYC(50)) uut (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .btn_in(btn_in), .rotor_pulse_in(rotor_pulse_in),
		.dm1_strobe_in(dm1_strobe_in), .dm1_lamp_in(dm1_lamp_in),
		.intake_out(outs[0]), .reverse_out(outs[1]), .alarm_out(outs[2]),
		.led_green_out(outs[3]), .led_red_out(outs[4]), .push_start_out(outs[5]),
		.in_range_out(outs[6]), .idle_cmd_out(outs[7]), .svc_flash_out(outs[8]),
		.fault_page_out(outs[9]));

	cic_far_end far (.clock_in(clock_in), .period_in(rotor_per), .lamp_in(lamp_req),
		.pulse_out(rotor_pulse_in), .strobe_out(dm1_strobe_in), .lamp_out(dm1_lamp_in));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// bounded wait for one output to reach a level, then judge it
	task wt(input int i, input logic v, input int lim);
		for (int n = 0; n < lim && outs[i] !== v; n++) @(posedge clock_in);
		chk(outs[i], v);
	endtask
	// count level changes of one output over a span
	task tog(input int i, input int cyc, output int n);
		logic last;
		n = 0;
		last = outs[i];
		repeat (cyc) begin
			@(posedge clock_in);
			n += int'(outs[i] !== last);
			last = outs[i];
		end
	endtask
	// apb transfer: request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		// no cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clock_in);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		re = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	// press long enough to pass the filter, then let it settle
	task press(input int b);
		@(posedge clock_in);
		btn_in[b] <= 1'b1;
		repeat (12) @(posedge clock_in);
		btn_in[b] <= 1'b0;
		repeat (12) @(posedge clock_in);
	endtask

	task t_regs;
		apb(1'b0, cic_pkg::OFS_CTRL, z);
		chk(rd, z);
		apb(1'b0, cic_pkg::OFS_SVC_INT, z);
		chk(rd, cic_pkg::SVC_INT_RST);
		for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i + 4), thr[i]);
		apb(1'b0, cic_pkg::OFS_THR_NORM, z);
		chk(rd, thr[2]);
		apb(1'b1, 8'h28, 32'h0000_0055);
		chk(re, 1'b1);
		$display("register test done");
	endtask
	task t_start;
		int n;
		chk(outs[ix_ps], 1'b1);
		press(0);
		chk(outs[ix_in], 1'b0);
		rotor_per <= 24'h00_00C8;
		wt(ix_ir, 1'b1, 1200);
		tog(ix_gr, 1000, n);
		chk(n >= 4 && n <= 6, 1'b1);
		press(0);
		wt(ix_in, 1'b1, 20);
		chk(outs[ix_ps], 1'b0);
		$display("start test done");
	endtask
	task t_under;
		int n;
		rotor_per <= 24'h00_01F4;
		wt(ix_in, 1'b0, 1500);
		wt(ix_rv, 1'b1, 4);
		tog(ix_rv, 18, n);
		chk(n, 0);
		wt(ix_rv, 1'b0, 4);
		rotor_per <= 24'h00_00C8;
		wt(ix_in, 1'b1, 1500);
		$display("underspeed test done");
	endtask
	task t_over;
		rotor_per <= 24'h00_0064;
		wt(ix_in, 1'b0, 600);
		wt(ix_ir, 1'b0, 5);
		rotor_per <= 24'h00_00C8;
		repeat (600) @(posedge clock_in);
		chk(outs[ix_in], 1'b0);
		rotor_per <= 24'h00_010E;
		wt(ix_in, 1'b1, 1200);
		rotor_per <= 24'h00_00C8;
		$display("overspeed test done");
	endtask
	task t_buttons;
		btn_in[2] <= 1'b1;
		wt(ix_rv, 1'b1, 20);
		chk(outs[ix_in], 1'b0);
		btn_in[2] <= 1'b0;
		wt(ix_in, 1'b1, 20);
		press(1);
		chk(outs[ix_in], 1'b0);
		chk(outs[ix_ps], 1'b1);
		btn_in[2] <= 1'b1;
		wt(ix_rv, 1'b1, 20);
		btn_in[2] <= 1'b0;
		repeat (20) @(posedge clock_in);
		chk(outs[ix_in], 1'b0);
		press(0);
		wt(ix_in, 1'b1, 20);
		$display("button test done");
	endtask
	task t_cover;
		btn_in[4] <= 1'b1;
		wt(ix_in, 1'b0, 20);
		wt(ix_al, 1'b1, 3);
		wt(ix_rd, 1'b1, 3);
		press(4);
		press(0);
		chk(outs[ix_in], 1'b0);
		press(3);
		chk(outs[ix_in], 1'b0);
		press(0);
		wt(ix_in, 1'b1, 20);
		wt(ix_al, 1'b0, 20);
		$display("cover test done");
	endtask
	task t_net;
		int n;
		apb(1'b1, cic_pkg::OFS_CTRL, 32'h0000_0001);
		wt(ix_id, 1'b1, 10);
		apb(1'b1, cic_pkg::OFS_CTRL, 32'h0000_0003);
		wt(ix_id, 1'b0, 10);
		lamp_req <= 2'h2;
		wt(ix_al, 1'b1, 60);
		wt(ix_rd, 1'b1, 5);
		tog(ix_rd, 60, n);
		chk(n, 0);
		tog(ix_pg, 60, n);
		chk(n >= 3, 1'b1);
		lamp_req <= 2'h1;
		wt(ix_al, 1'b0, 60);
		tog(ix_rd, 60, n);
		chk(n >= 3, 1'b1);
		lamp_req <= 2'h0;
		repeat (120) @(posedge clock_in);
		tog(ix_pg, 40, n);
		chk(n, 0);
		chk(outs[ix_rd], 1'b0);
		$display("engine fault test done");
	endtask
	task t_svc;
		int n;
		apb(1'b1, cic_pkg::OFS_SVC_HOURS, 32'h0000_01F4);
		tog(ix_sv, 40, n);
		chk(n, 0);
		apb(1'b1, cic_pkg::OFS_SVC_HOURS, 32'h0000_01F5);
		tog(ix_sv, 40, n);
		chk(n >= 3, 1'b1);
		$display("service test done");
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// main sequence after a six-cycle reset
	initial begin
		repeat (6) @(posedge clock_in);
		reset_n_in <= 1'b1;
		t_regs;
		t_start;
		t_under;
		t_over;
		t_buttons;
		t_cover;
		t_net;
		t_svc;
		wrap_up;
	end
	// watchdog: tests need well under a third of this span
	initial begin
		repeat (30000) @(posedge clock_in);
		err_total++;
		wrap_up;
	end
endmodule
